// ---- shared/irac_cfg.svh ----
/*
 Offsets, field positions, reset values and fixed patterns of the
 reservation adapter control register bank.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef IRAC_CFG_SVH
`define IRAC_CFG_SVH

`define IRAC_CTRL_OFFSET 12'h000
`define IRAC_IRQ_STAT_OFFSET 12'h004
`define IRAC_IRQ_MASK_OFFSET 12'h008

`define IRAC_BIT_ADAPTER_EN 7
`define IRAC_BIT_CMD_IRQ_EN 6
`define IRAC_BIT_MASTER_IRQ_EN 5
`define IRAC_BIT_SLAVE_IRQ_EN 4
`define IRAC_BIT_BUS_OCC 3
`define IRAC_BIT_RESERVED 2
`define IRAC_BIT_ADDR_HIT 1
`define IRAC_BIT_ACK_RESERVE 0

`define IRAC_CTRL_RESET 4'h0
`define IRAC_CLEAR_KEY 4'h5

`define IRAC_EVT_CMD 0
`define IRAC_EVT_MASTER 1
`define IRAC_EVT_SLAVE 2
`define IRAC_EVT_CLEAR 3
`define IRAC_NUM_EVT 4

`endif

// ---- shared/irac_pkg.sv ----
/*
 Types shared by the reservation adapter control bank.
 Assumes irac_cfg.svh is on the include path.
*/
package irac_pkg;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} irac_apb_req_t;

	typedef struct packed {
		logic command_write_request;
		logic master_rx_request;
		logic master_tx_request;
		logic slave_rx_request;
		logic slave_tx_request;
	} irac_req_t;

	typedef struct packed {
		logic bus_occupied_flag;
		logic own_address_hit;
		logic ack_reply_reserve;
	} irac_stat_t;

	typedef struct packed {
		logic cmd_irq;
		logic master_irq;
		logic slave_irq;
	} irac_irq_t;
endpackage

// ---- verilog/irac_ctrl.sv ----
/*
 APB register bank controlling the reservation adapter: adapter enable,
 interrupt enables, read-only bus status and a keyed module clear.
 Assumes request inputs come from logic on pclk; all three status bits
 arrive from the pin side and are synchronised here.
*/
// Contract
// - Command request irq gated by enable bit
// - Bit 5 gates master rx/tx irqs
// - Bit 4 gates slave rx/tx irqs
// - Bit 3 reports bus occupied, read-only
// - Bit 2 reads zero, unwritable
// - Bit 1 reports own address hit
// - Bit 0 shows reserved ack value
// - Writing 0101 to bits 3:0 clears module
// - Read-modify-write never forms clear pattern
// - Adapter enable hands bus pins to adapter
`timescale 1ns/1ns
`include "irac_cfg.svh"

module irac_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire irac_pkg::irac_apb_req_t apb_req,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	input wire irac_pkg::irac_req_t req_in,
	input wire irac_pkg::irac_stat_t stat_in,
	output irac_pkg::irac_irq_t irq_out,
	output logic adapter_enable,
	output logic pins_drive_en,
	output logic module_clear,
	output logic irq
);
	import irac_pkg::*;

	logic adapter_enable_nxt;
	logic cmd_req_irq_en_r;
	logic cmd_req_irq_en_nxt;
	logic master_xfer_irq_en_r;
	logic master_xfer_irq_en_nxt;
	logic slave_xfer_irq_en_r;
	logic slave_xfer_irq_en_nxt;
	logic bus_occ_s1_r;
	logic bus_occ_s2_r;
	logic addr_hit_s1_r;
	logic addr_hit_s2_r;
	logic ack_res_s1_r;
	logic ack_res_s2_r;
	logic [`IRAC_NUM_EVT-1:0] evt_stat_r;
	logic [`IRAC_NUM_EVT-1:0] evt_mask_r;
	logic [`IRAC_NUM_EVT-1:0] evt_now;
	logic [`IRAC_NUM_EVT-1:0] evt_prev_r;
	logic [`IRAC_NUM_EVT-1:0] evt_rise;
	logic [`IRAC_NUM_EVT-1:0] evt_w1c;
	logic setup_phase;
	logic wr_en;
	logic rd_en;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_mask;
	logic sel_ctrl;
	logic sel_stat;
	logic sel_mask;
	logic clear_hit;
	logic [7:0] ctrl_view;
	logic [31:0] rd_nxt;
	logic pslverr_nxt;
	logic irq_nxt;
	logic cmd_irq_nxt;
	logic master_irq_nxt;
	logic slave_irq_nxt;

	function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
		addr_is = (a == off);
	endfunction

	function automatic logic addr_known(input logic [11:0] a);
		addr_known = addr_is(a, `IRAC_CTRL_OFFSET) || addr_is(a, `IRAC_IRQ_STAT_OFFSET)
			|| addr_is(a, `IRAC_IRQ_MASK_OFFSET);
	endfunction

	// Both halves of a group raise the same line
	function automatic logic group_req(input logic rx, input logic tx, input logic en);
		group_req = (rx || tx) && en;
	endfunction

	// Decodes shared by the write and read paths
	assign sel_ctrl = addr_is(apb_req.paddr, `IRAC_CTRL_OFFSET);
	assign sel_stat = addr_is(apb_req.paddr, `IRAC_IRQ_STAT_OFFSET);
	assign sel_mask = addr_is(apb_req.paddr, `IRAC_IRQ_MASK_OFFSET);

	// Zero-wait slave: access phase completes on its first edge
	assign setup_phase = apb_req.psel && !apb_req.penable;
	assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign rd_en = setup_phase && !apb_req.pwrite;
	assign wr_ctrl = wr_en && sel_ctrl;
	assign wr_stat = wr_en && sel_stat;
	assign wr_mask = wr_en && sel_mask;

	// Bits 3:0 written back by read-modify-write carry bit 2 as zero
	assign clear_hit = wr_ctrl && (apb_req.pwdata[3:0] == `IRAC_CLEAR_KEY);

	// Status from the bus side crosses into pclk, one pair per bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_occ_s1_r <= 1'b0;
			bus_occ_s2_r <= 1'b0;
		end else begin
			bus_occ_s1_r <= stat_in.bus_occupied_flag;
			bus_occ_s2_r <= bus_occ_s1_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_hit_s1_r <= 1'b0;
			addr_hit_s2_r <= 1'b0;
		end else begin
			addr_hit_s1_r <= stat_in.own_address_hit;
			addr_hit_s2_r <= addr_hit_s1_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_res_s1_r <= 1'b0;
			ack_res_s2_r <= 1'b0;
		end else begin
			ack_res_s1_r <= stat_in.ack_reply_reserve;
			ack_res_s2_r <= ack_res_s1_r;
		end
	end

	// Only the second stage feeds the read path
	always_comb begin
		ctrl_view = 8'h00;
		ctrl_view[`IRAC_BIT_ADAPTER_EN] = adapter_enable;
		ctrl_view[`IRAC_BIT_CMD_IRQ_EN] = cmd_req_irq_en_r;
		ctrl_view[`IRAC_BIT_MASTER_IRQ_EN] = master_xfer_irq_en_r;
		ctrl_view[`IRAC_BIT_SLAVE_IRQ_EN] = slave_xfer_irq_en_r;
		ctrl_view[`IRAC_BIT_BUS_OCC] = bus_occ_s2_r;
		ctrl_view[`IRAC_BIT_RESERVED] = 1'b0;
		ctrl_view[`IRAC_BIT_ADDR_HIT] = addr_hit_s2_r;
		ctrl_view[`IRAC_BIT_ACK_RESERVE] = ack_res_s2_r;
	end

	// Key wins over the upper bits of the same write
	always_comb begin
		adapter_enable_nxt = adapter_enable;
		cmd_req_irq_en_nxt = cmd_req_irq_en_r;
		master_xfer_irq_en_nxt = master_xfer_irq_en_r;
		slave_xfer_irq_en_nxt = slave_xfer_irq_en_r;
		if (clear_hit) begin
			adapter_enable_nxt = 1'b0;
			cmd_req_irq_en_nxt = 1'b0;
			master_xfer_irq_en_nxt = 1'b0;
			slave_xfer_irq_en_nxt = 1'b0;
		end else if (wr_ctrl) begin
			adapter_enable_nxt = apb_req.pwdata[`IRAC_BIT_ADAPTER_EN];
			cmd_req_irq_en_nxt = apb_req.pwdata[`IRAC_BIT_CMD_IRQ_EN];
			master_xfer_irq_en_nxt = apb_req.pwdata[`IRAC_BIT_MASTER_IRQ_EN];
			slave_xfer_irq_en_nxt = apb_req.pwdata[`IRAC_BIT_SLAVE_IRQ_EN];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adapter_enable <= 1'b0;
		end else begin
			adapter_enable <= adapter_enable_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_req_irq_en_r <= 1'b0;
		end else begin
			cmd_req_irq_en_r <= cmd_req_irq_en_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			master_xfer_irq_en_r <= 1'b0;
		end else begin
			master_xfer_irq_en_r <= master_xfer_irq_en_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slave_xfer_irq_en_r <= 1'b0;
		end else begin
			slave_xfer_irq_en_r <= slave_xfer_irq_en_nxt;
		end
	end

	// One-cycle pulse; the controller side treats it as a reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			module_clear <= 1'b0;
		end else begin
			module_clear <= clear_hit;
		end
	end

	// Pins let go in the same cycle as the clear pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_drive_en <= 1'b0;
		end else begin
			pins_drive_en <= adapter_enable && !clear_hit;
		end
	end

	// Gated request outputs follow flags and enables
	assign cmd_irq_nxt = req_in.command_write_request && cmd_req_irq_en_r;
	assign master_irq_nxt = group_req(req_in.master_rx_request, req_in.master_tx_request,
		master_xfer_irq_en_r);
	assign slave_irq_nxt = group_req(req_in.slave_rx_request, req_in.slave_tx_request,
		slave_xfer_irq_en_r);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_out.cmd_irq <= 1'b0;
		end else begin
			irq_out.cmd_irq <= cmd_irq_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_out.master_irq <= 1'b0;
		end else begin
			irq_out.master_irq <= master_irq_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_out.slave_irq <= 1'b0;
		end else begin
			irq_out.slave_irq <= slave_irq_nxt;
		end
	end

	always_comb begin
		evt_now = '0;
		evt_now[`IRAC_EVT_CMD] = irq_out.cmd_irq;
		evt_now[`IRAC_EVT_MASTER] = irq_out.master_irq;
		evt_now[`IRAC_EVT_SLAVE] = irq_out.slave_irq;
		evt_now[`IRAC_EVT_CLEAR] = clear_hit;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_prev_r <= '0;
		end else begin
			evt_prev_r <= evt_now;
		end
	end

	// Edge, not level, so a held request sets the bit once
	assign evt_rise = evt_now & ~evt_prev_r;
	assign evt_w1c = wr_stat ? apb_req.pwdata[`IRAC_NUM_EVT-1:0] : '0;

	// Sticky status: a rising event beats a write-one clear
	generate
		for (genvar i = 0; i < `IRAC_NUM_EVT; i++) begin : g_evt
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					evt_stat_r[i] <= 1'b0;
				end else if (evt_rise[i]) begin
					evt_stat_r[i] <= 1'b1;
				end else if (evt_w1c[i]) begin
					evt_stat_r[i] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_mask_r <= '0;
		end else if (wr_mask) begin
			evt_mask_r <= apb_req.pwdata[`IRAC_NUM_EVT-1:0];
		end
	end

	// Registered, so the line lags the status by one cycle
	assign irq_nxt = |(evt_stat_r & evt_mask_r);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= irq_nxt;
		end
	end

	// Unmapped offsets read as zero
	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (sel_ctrl) begin
			rd_nxt = {24'h000000, ctrl_view};
		end else if (sel_stat) begin
			rd_nxt = {28'h0000000, evt_stat_r};
		end else if (sel_mask) begin
			rd_nxt = {28'h0000000, evt_mask_r};
		end
	end

	// Read data captured in setup so it is stable in access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata <= rd_nxt;
		end
	end

	assign pslverr_nxt = setup_phase && !addr_known(apb_req.paddr);

	// No wait states: ready rises for exactly the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup_phase;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= pslverr_nxt;
		end
	end
endmodule

// ---- sim/irac_ctrl_checker.sv ----
/*
 Checker for the adapter control bank, bound to irac_ctrl.
 Assumes zero-wait APB and registered outputs.
*/
`timescale 1ns/1ns
module irac_ctrl_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire irac_pkg::irac_apb_req_t apb_req,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire irac_pkg::irac_req_t req_in,
	input wire irac_pkg::irac_irq_t irq_out,
	input wire logic adapter_enable,
	input wire logic pins_drive_en,
	input wire logic module_clear
);
	import irac_pkg::*;
	logic [7:4] en_r;
	wire wr0 = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == 12'h000;
	wire key = wr0 && apb_req.pwdata[3:0] == 4'h5;
	// Shadow of the enables, so gating is judged without reading the bank
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) en_r <= 4'h0;
		else if (key) en_r <= 4'h0;
		else if (wr0) en_r <= apb_req.pwdata[7:4];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_pulse; module_clear ##1 !module_clear; endsequence
	property p_cmd; irq_out.cmd_irq == $past(req_in.command_write_request && en_r[6]); endproperty
	property p_mst; irq_out.master_irq ==
		$past((req_in.master_rx_request || req_in.master_tx_request) && en_r[5]); endproperty
	property p_slv; irq_out.slave_irq ==
		$past((req_in.slave_rx_request || req_in.slave_tx_request) && en_r[4]); endproperty
	property p_ena; adapter_enable == en_r[7]; endproperty
	property p_pin; pins_drive_en == $past(adapter_enable && !key); endproperty
	property p_clr; key |=> s_pulse; endproperty
	property p_one; module_clear |-> $past(key); endproperty
	property p_rsv; pready && !apb_req.pwrite && apb_req.paddr == 12'h000 |-> !prdata[2];
	endproperty
	a_cmd: assert property (p_cmd) else $error("cmd irq wrong");
	a_mst: assert property (p_mst) else $error("master irq wrong");
	a_slv: assert property (p_slv) else $error("slave irq wrong");
	a_ena: assert property (p_ena) else $error("enable bit wrong");
	a_pin: assert property (p_pin) else $error("pin drive wrong");
	a_clr: assert property (p_clr) else $error("no clear pulse");
	a_one: assert property (p_one) else $error("stray clear");
	a_rsv: assert property (p_rsv) else $error("bit 2 set");
endmodule

bind irac_ctrl irac_ctrl_checker u_irac_ctrl_checker (.pclk(pclk), .presetn(presetn),
	.apb_req(apb_req), .pready(pready), .prdata(prdata), .req_in(req_in), .irq_out(irq_out),
	.adapter_enable(adapter_enable), .pins_drive_en(pins_drive_en), .module_clear(module_clear));

// ---- sim/testbench.sv ----
/*
 Self-checking bench for irac_ctrl.
 Assumes the checker is bound separately.
*/
`timescale 1ns/1ns
module testbench;
	import irac_pkg::*;
	logic pclk = 0, presetn = 0, pready, pslverr, ae, pde, mc, irq, se;
	logic [31:0] prdata, rd;
	irac_apb_req_t ar = '0;
	irac_req_t rq = '0;
	irac_stat_t st = '0;
	irac_irq_t io;
	int error_cnt = 0, comparisons = 0;
	always #2 pclk = ~pclk;
	irac_ctrl u_irac_ctrl (.pclk(pclk), .presetn(presetn), .apb_req(ar), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .req_in(rq), .stat_in(st), .irq_out(io),
		.adapter_enable(ae), .pins_drive_en(pde), .module_clear(mc), .irq(irq));
	task chk(input [31:0] g, e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Read data and error taken at the edge that sees pready
	task apb(input w, input [11:0] a, input [31:0] d);
		@(posedge pclk);
		ar <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		ar.penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		ar <= '0;
	endtask
	task t_fields;
		apb(0, 12'h000, 0); chk(rd, 32'h0);
		apb(1, 12'h000, 32'hF4); apb(0, 12'h000, 0); chk(rd, 32'hF0);
		chk(ae, 1);
		chk(pde, 1);
		st <= '1;
		apb(0, 12'h000, 0); apb(0, 12'h000, 0); chk(rd, 32'hFB);
		apb(1, 12'h000, rd); @(posedge pclk); chk(mc, 0);
		apb(0, 12'h000, 0); chk(rd, 32'hFB);
	endtask
	task t_irq;
		rq <= '1;
		for (int i = 0; i < 3; i++) begin
			apb(1, 12'h000, 32'h10 << i); @(posedge pclk); @(posedge pclk);
			chk(io, 1 << i);
		end
		rq <= '0; @(posedge pclk); @(posedge pclk); chk(io, 0);
	endtask
	task t_clear;
		st <= '0;
		apb(1, 12'h008, 32'h8); apb(1, 12'h004, 32'hF); chk(irq, 0);
		apb(1, 12'h000, 32'hF0); @(posedge pclk); chk(ae, 1);
		apb(1, 12'h000, 32'hF5); @(posedge pclk); chk(mc, 1);
		chk(ae, 0);
		apb(1, 12'h000, 32'h0);
		apb(0, 12'h000, 0); chk(rd, 32'h0);
		chk(irq, 1);
		apb(1, 12'h004, 32'h8); @(posedge pclk); @(posedge pclk); chk(irq, 0);
		apb(0, 12'h00C, 0); chk(se, 1);
	endtask
	task wrap_up;
		$display("Errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		t_fields; t_irq; t_clear; wrap_up;
	end
	// Whole run is under 150 cycles
	initial begin
		#4000;
		error_cnt++;
		wrap_up;
	end
endmodule
